/* rtl/pec_top.sv */
// Edge timing for drive outputs C and D with an APB register bank.
// Assumes an APB master on pclk and a loop modulation term on pclk.
`timescale 1ns/1ps
`default_nettype none

module pec_top #(
    parameter int unsigned MOD_W = 12
) (
    // Clock and reset
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    // APB slave
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [pec_pkg::ADDR_W-1:0]     paddr,
    input  wire logic [pec_pkg::DATA_W-1:0]     pwdata,
    input  wire logic [3:0]                     pstrb,
    output logic                                pready,
    output logic [pec_pkg::DATA_W-1:0]          prdata,
    output logic                                pslverr,
    // Loop modulation term
    input  wire logic signed [MOD_W-1:0]        mod_term,
    // Drive outputs
    output pec_pkg::pec_drive_type              drive
);
    import pec_pkg::*;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (MOD_W < 2 || MOD_W > EDGE_W + 1) begin : g_bad_mod_w
        $error("MOD_W out of range");
    end
    if (STEPS_PER_CLK < 1) begin : g_bad_steps
        $error("clock slower than step required");
    end

    localparam logic [EDGE_W:0] STEPS = (EDGE_W+1)'(STEPS_PER_CLK);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] merge_byte(
        input logic [7:0] old_v,
        input logic [7:0] new_v,
        input logic       lane
    );
        return lane ? new_v : old_v;
    endfunction

    function automatic logic in_window(
        input logic [EDGE_W-1:0] edge_t,
        input logic [EDGE_W-1:0] cnt
    );
        logic [EDGE_W:0] e;
        logic [EDGE_W:0] c;
        e = {1'b0, edge_t};
        c = {1'b0, cnt};
        return (e >= c) && (e < c + STEPS);
    endfunction

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0]        high_q [EDGE_CNT];
    logic [7:0]        high_d [EDGE_CNT];
    logic [7:0]        set_q  [EDGE_CNT];
    logic [7:0]        set_d  [EDGE_CNT];
    logic [EDGE_W-1:0] period_q;
    logic [EDGE_W-1:0] period_d;
    logic              run_q;
    logic              run_d;
    logic              pready_q;
    logic              pready_d;
    logic [DATA_W-1:0] prdata_q;
    logic [DATA_W-1:0] prdata_d;
    logic              pslverr_q;
    logic              pslverr_d;

    // ------------------------------------------------------------
    // Timing state
    // ------------------------------------------------------------
    logic [EDGE_W-1:0] cnt_q;
    logic [EDGE_W-1:0] cnt_d;
    logic [EDGE_W-1:0] edge_q [EDGE_CNT];
    logic [EDGE_W-1:0] edge_d [EDGE_CNT];
    pec_drive_type     drive_q;
    pec_drive_type     drive_d;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic       setup;
    logic       access;
    logic       mapped;
    logic [7:0] idx;

    always_comb begin
        setup  = psel && !penable;
        access = psel && penable && pready_q;
        idx    = paddr[9:2];
        mapped = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0)
              && ((idx == IDX_PERIOD) || (idx == IDX_CTRL)
              || (idx == IDX_STATUS));
        for (int k = 0; k < EDGE_CNT; k++) begin
            if (idx == IDX_HIGH[k] || idx == IDX_SET[k]) begin
                mapped = mapped || ((paddr[1:0] == 2'b00)
                      && (paddr[ADDR_W-1:10] == '0));
            end
        end
    end

    // ------------------------------------------------------------
    // Register file next state
    // ------------------------------------------------------------
    always_comb begin
        high_d    = high_q;
        set_d     = set_q;
        period_d  = period_q;
        run_d     = run_q;
        pready_d  = setup;
        pslverr_d = setup && !mapped;
        prdata_d  = prdata_q;
        if (setup && !pwrite) begin
            prdata_d = '0;
            for (int k = 0; k < EDGE_CNT; k++) begin
                if (idx == IDX_HIGH[k]) begin
                    prdata_d[7:0] = high_q[k];
                end
                if (idx == IDX_SET[k]) begin
                    prdata_d[7:0] = set_q[k];
                end
            end
            if (idx == IDX_PERIOD) begin
                prdata_d[EDGE_W-1:0] = period_q;
            end
            if (idx == IDX_CTRL) begin
                prdata_d[CTRL_RUN_BIT] = run_q;
            end
            if (idx == IDX_STATUS) begin
                prdata_d[STAT_C_BIT]   = drive_q.drive_output_c;
                prdata_d[STAT_D_BIT]   = drive_q.drive_output_d;
                prdata_d[STAT_RUN_BIT] = run_q;
                prdata_d[STAT_CNT_LSB +: EDGE_W] = cnt_q;
            end
            if (!mapped) begin
                prdata_d = '0;
            end
        end
        if (access && pwrite && !pslverr_q) begin
            for (int k = 0; k < EDGE_CNT; k++) begin
                if (idx == IDX_HIGH[k]) begin
                    high_d[k] = merge_byte(high_q[k], pwdata[7:0],
                                           pstrb[0]);
                end
                if (idx == IDX_SET[k]) begin
                    set_d[k] = merge_byte(set_q[k], pwdata[7:0],
                                          pstrb[0]);
                end
            end
            if (idx == IDX_PERIOD) begin
                period_d[7:0] = merge_byte(period_q[7:0], pwdata[7:0],
                                           pstrb[0]);
                period_d[EDGE_W-1:8] = pstrb[1] ? pwdata[EDGE_W-1:8]
                                                : period_q[EDGE_W-1:8];
            end
            if (idx == IDX_CTRL && pstrb[0]) begin
                run_d = pwdata[CTRL_RUN_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < EDGE_CNT; k++) begin
                high_q[k] <= TIME_HIGH_RST;
                set_q[k]  <= SETTING_RST;
            end
            period_q  <= PERIOD_RST;
            run_q     <= RUN_RST;
            pready_q  <= 1'b0;
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end else begin
            high_q    <= high_d;
            set_q     <= set_d;
            period_q  <= period_d;
            run_q     <= run_d;
            pready_q  <= pready_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ------------------------------------------------------------
    // Edge placement
    // ------------------------------------------------------------
    pec_edge_cfg_type  cfg    [EDGE_CNT];
    logic [EDGE_W-1:0] placed [EDGE_CNT];

    for (genvar g = 0; g < EDGE_CNT; g++) begin : g_edge
        assign cfg[g] = pec_decode(high_q[g], set_q[g]);
        pec_edge_place #(
            .MOD_W    (MOD_W)
        ) u_place (
            .cfg      (cfg[g]),
            .mod_term (mod_term),
            .placed   (placed[g])
        );
    end

    // ------------------------------------------------------------
    // Period counter and drive outputs
    // ------------------------------------------------------------
    logic            wrap;
    logic [EDGE_W:0] cnt_next;
    logic            hit_c_rise;
    logic            hit_c_fall;
    logic            hit_d_rise;

    always_comb begin
        cnt_next   = {1'b0, cnt_q} + STEPS;
        wrap       = cnt_next >= {1'b0, period_q};
        hit_c_rise = in_window(edge_q[E_C_RISE], cnt_q);
        hit_c_fall = in_window(edge_q[E_C_FALL], cnt_q);
        hit_d_rise = in_window(edge_q[E_D_RISE], cnt_q);
        cnt_d      = cnt_q;
        edge_d     = edge_q;
        drive_d    = drive_q;
        if (!run_q) begin
            cnt_d   = '0;
            edge_d  = placed;
            drive_d = '0;
        end else begin
            if (hit_c_fall) begin
                drive_d.drive_output_c = 1'b0;
            end else if (hit_c_rise) begin
                drive_d.drive_output_c = 1'b1;
            end
            if (wrap) begin
                cnt_d  = '0;
                edge_d = placed;
                drive_d.drive_output_d = 1'b0;
            end else begin
                cnt_d = cnt_next[EDGE_W-1:0];
                if (hit_d_rise) begin
                    drive_d.drive_output_d = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            for (int k = 0; k < EDGE_CNT; k++) begin
                edge_q[k] <= '0;
            end
            drive_q <= '0;
        end else begin
            cnt_q   <= cnt_d;
            edge_q  <= edge_d;
            drive_q <= drive_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pready  = pready_q;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;
    assign drive   = drive_q;

endmodule

`default_nettype wire

/* include/pec_pkg.sv */
// Constants, types and helpers shared by the edge timing block.
// Assumes a 40 MHz APB clock and 5 ns edge time steps.
`default_nettype none

package pec_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned EDGE_W   = 12;
    localparam int unsigned BYTE_W   = 8;
    localparam int unsigned ADDR_W   = 12;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned EDGE_CNT = 3;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_C_RISE_HIGH = 8'h49;
    localparam logic [7:0] IDX_C_RISE_SET  = 8'h4A;
    localparam logic [7:0] IDX_C_FALL_HIGH = 8'h4B;
    localparam logic [7:0] IDX_C_FALL_SET  = 8'h4C;
    localparam logic [7:0] IDX_D_RISE_HIGH = 8'h4D;
    localparam logic [7:0] IDX_D_RISE_SET  = 8'h4E;
    localparam logic [7:0] IDX_PERIOD      = 8'h60;
    localparam logic [7:0] IDX_CTRL        = 8'h61;
    localparam logic [7:0] IDX_STATUS      = 8'h62;

    localparam logic [7:0] IDX_HIGH [EDGE_CNT] =
        '{IDX_C_RISE_HIGH, IDX_C_FALL_HIGH, IDX_D_RISE_HIGH};
    localparam logic [7:0] IDX_SET  [EDGE_CNT] =
        '{IDX_C_RISE_SET, IDX_C_FALL_SET, IDX_D_RISE_SET};

    // ------------------------------------------------------------
    // Edge order inside the arrays
    // ------------------------------------------------------------
    localparam int unsigned E_C_RISE = 0;
    localparam int unsigned E_C_FALL = 1;
    localparam int unsigned E_D_RISE = 2;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned SET_LOW_MSB    = 7;
    localparam int unsigned SET_LOW_LSB    = 4;
    localparam int unsigned SET_MOD_EN_BIT = 3;
    localparam int unsigned SET_SIGN_BIT   = 2;
    localparam int unsigned CTRL_RUN_BIT   = 0;
    localparam int unsigned STAT_C_BIT     = 0;
    localparam int unsigned STAT_D_BIT     = 1;
    localparam int unsigned STAT_RUN_BIT   = 2;
    localparam int unsigned STAT_CNT_LSB   = 16;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]        TIME_HIGH_RST = 8'h00;
    localparam logic [7:0]        SETTING_RST   = 8'h00;
    localparam logic [EDGE_W-1:0] PERIOD_RST    = 12'h0C8;
    localparam logic              RUN_RST       = 1'b0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned STEP_NS       = 5;
    localparam int unsigned STEPS_PER_CLK = CLK_PERIOD_NS / STEP_NS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [EDGE_W-1:0] time_steps;
        logic              mod_en;
        logic              neg_sign;
    } pec_edge_cfg_type;

    typedef struct packed {
        logic drive_output_c;
        logic drive_output_d;
    } pec_drive_type;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic pec_edge_cfg_type pec_decode(
        input logic [7:0] high,
        input logic [7:0] setting
    );
        pec_edge_cfg_type cfg;
        cfg.time_steps = {high, setting[SET_LOW_MSB:SET_LOW_LSB]};
        cfg.mod_en     = setting[SET_MOD_EN_BIT];
        cfg.neg_sign   = setting[SET_SIGN_BIT];
        return cfg;
    endfunction

    function automatic logic [ADDR_W-1:0] pec_byte_addr(
        input logic [7:0] idx
    );
        return {2'b00, idx, 2'b00};
    endfunction

endpackage

`default_nettype wire

/* rtl/pec_edge_place.sv */
// Places one edge: programmed time moved by the loop modulation term.
// Assumes mod_term is a signed count of 5 ns steps on the same clock.
`timescale 1ns/1ps
`default_nettype none

module pec_edge_place #(
    parameter int unsigned MOD_W = 12
) (
    // Edge setting
    input  wire pec_pkg::pec_edge_cfg_type cfg,
    // Modulation
    input  wire logic signed [MOD_W-1:0]   mod_term,
    // Result in steps
    output logic [pec_pkg::EDGE_W-1:0]     placed
);
    import pec_pkg::*;

    localparam int unsigned SUM_W = EDGE_W + 2;
    localparam logic signed [SUM_W-1:0] MAX_T = {2'b00, {EDGE_W{1'b1}}};

    logic signed [SUM_W-1:0] base;
    logic signed [SUM_W-1:0] offs;
    logic signed [SUM_W-1:0] sum;

    always_comb begin
        base = signed'({2'b00, cfg.time_steps});
        offs = signed'({{(SUM_W-MOD_W){mod_term[MOD_W-1]}}, mod_term});
        if (!cfg.mod_en) begin
            sum = base;
        end else if (cfg.neg_sign) begin
            sum = base + offs;
        end else begin
            sum = base - offs;
        end
        if (sum < 0) begin
            placed = '0;
        end else if (sum > MAX_T) begin
            placed = {EDGE_W{1'b1}};
        end else begin
            placed = sum[EDGE_W-1:0];
        end
    end

endmodule

`default_nettype wire

/* sim/pec_assertions.sv */
// Checker for the APB side of the edge timing block, with covers on the drive outputs.
// Assumes it is bound to pec_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module pec_assertions
    import pec_pkg::*;
#(
    parameter int unsigned MOD_W = 12
) (
    // Clock and reset
    input wire logic                 pclk,
    input wire logic                 presetn,
    // APB
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [ADDR_W-1:0]    paddr,
    input wire logic                 pready,
    input wire logic [DATA_W-1:0]    prdata,
    input wire logic                 pslverr,
    // Drive outputs
    input wire pec_pkg::pec_drive_type drive
);
    logic setup;
    assign setup = psel & ~penable;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_rdy_after_setup;
        setup |=> pready;
    endproperty
    a_rdy_after_setup: assert property (p_rdy_after_setup)
        else $error("pready missing after setup");
    property p_rdy_one;
        pready |=> !pready;
    endproperty
    a_rdy_one: assert property (p_rdy_one)
        else $error("pready held too long");
    property p_rdy_in_access;
        pready |-> psel && penable;
    endproperty
    a_rdy_in_access: assert property (p_rdy_in_access)
        else $error("pready outside access");
    property p_err_with_rdy;
        pslverr |-> pready;
    endproperty
    a_err_with_rdy: assert property (p_err_with_rdy)
        else $error("pslverr without pready");
    property p_err_misalign;
        setup && (paddr[1:0] != 2'h0) |=> pslverr;
    endproperty
    a_err_misalign: assert property (p_err_misalign)
        else $error("misaligned access not refused");
    property p_err_unmapped;
        setup && !pwrite && (paddr[11:10] != 2'h0)
            |=> pslverr && (prdata == 32'h0);
    endproperty
    a_err_unmapped: assert property (p_err_unmapped)
        else $error("unmapped read not refused");
    property p_ok_mapped;
        setup && (paddr == 12'h124 || paddr == 12'h138) |=> !pslverr;
    endproperty
    a_ok_mapped: assert property (p_ok_mapped)
        else $error("mapped edge register refused");
    property p_prdata_hold;
        !(setup && !pwrite) |=> $stable(prdata);
    endproperty
    a_prdata_hold: assert property (p_prdata_hold)
        else $error("read data changed without read");
    property p_edge_upper_zero;
        pready && !pwrite && (paddr[11:2] >= 10'h049)
            && (paddr[11:2] <= 10'h04E) && (paddr[1:0] == 2'h0)
            |-> prdata[31:8] == 24'h0;
    endproperty
    a_edge_upper_zero: assert property (p_edge_upper_zero)
        else $error("edge register upper bits set");

    c_write: cover property (setup && pwrite ##1 pready);
    c_err: cover property (pslverr);
    c_c_rise: cover property ($rose(drive.drive_output_c));
    c_d_rise: cover property ($rose(drive.drive_output_d));
endmodule

bind pec_top pec_assertions #(.MOD_W(MOD_W)) u_pec_assertions (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pready, .prdata, .pslverr, .drive);

`default_nettype wire

/* sim/pec_gate_model.sv */
// Gate driver model: measures C high time and D rise delay in clocks.
// Assumes drive levels change on pclk rising edges.
`timescale 1ns/1ps
`default_nettype none

module pec_gate_model (
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // Switch drive
    input  wire pec_pkg::pec_drive_type drive,
    // Measurements
    output logic                        meas_v,
    output logic [7:0]                  c_w,
    output logic [7:0]                  d_dly
);
    logic       c_p;
    logic       d_p;
    logic [7:0] k;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {c_p, d_p, meas_v, c_w, d_dly, k} <= '0;
        end else begin
            c_p    <= drive.drive_output_c;
            d_p    <= drive.drive_output_d;
            meas_v <= c_p & ~drive.drive_output_c;
            if (c_p & ~drive.drive_output_c) begin
                c_w <= k;
            end
            if (drive.drive_output_c & ~c_p) begin
                k <= 8'h01;
                if (drive.drive_output_d & ~d_p) begin
                    d_dly <= 8'h00;
                end
            end else begin
                if (drive.drive_output_c) begin
                    k <= k + 8'h01;
                end
                if (drive.drive_output_d & ~d_p) begin
                    d_dly <= k;
                end
            end
        end
    end
endmodule

`default_nettype wire

/* sim/pec_top_test.sv */
// Testbench: APB register checks and edge placement on drive outputs.
// Assumes zero-wait APB slave and a 25 ns clock.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
    miscompares++; $display("wrong value %s exp %h got %h", nm, ex, got); \
    end end

module pec_top_test;
    import pec_pkg::*;

    logic               pclk = 1'b0;
    logic               presetn = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [ADDR_W-1:0]  paddr = '0;
    logic [DATA_W-1:0]  pwdata = '0;
    logic [3:0]         pstrb = 4'h0;
    logic               pready;
    logic [DATA_W-1:0]  prdata;
    logic               pslverr;
    logic signed [11:0] mod_term = 12'h000;
    pec_drive_type      drive;
    logic               meas_v;
    logic [7:0]         c_w;
    logic [7:0]         d_dly;
    logic [33:0]        exq[$];
    logic [15:0]        wq[$];
    int                 miscompares = 0;
    int                 cmp_count = 0;

    pec_top u_pec_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .pready, .prdata, .pslverr, .mod_term, .drive);
    pec_gate_model u_pec_gate_model (.pclk, .presetn, .drive, .meas_v,
        .c_w, .d_dly);

    initial begin
        forever #12.5 pclk = ~pclk;
    end

    function automatic logic [11:0] ba(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s, input logic [32:0] e);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
        exq.push_back({w, e});
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF, 33'h0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, $urandom, 4'hF, {1'b0, e});
    endtask

    task automatic row(input logic [7:0] i, input logic [7:0] v,
        input logic [11:0] m, input logic [7:0] w, input logic [7:0] dd);
        wr(ba(i), {24'h0, v});
        mod_term <= m;
        repeat (24) @(posedge pclk);
        wq.push_back({w, dd});
        while (wq.size() > 0) begin
            @(posedge pclk);
        end
    endtask

    // ----------------------------------------------------------------
    // Result watchers
    // ----------------------------------------------------------------
    always @(posedge pclk) begin
        logic [33:0] e;
        if (psel && penable && pready === 1'b1 && exq.size() > 0) begin
            e = exq.pop_front();
            `CHK("pslverr", e[32], pslverr)
            if (!e[33]) `CHK("prdata", e[31:0], prdata)
        end
    end

    always @(posedge pclk) begin
        logic [15:0] e;
        if (meas_v === 1'b1 && wq.size() > 0) begin
            e = wq.pop_front();
            `CHK("c_high", e[15:8], c_w)
            `CHK("d_delay", e[7:0], d_dly)
        end
    end

    initial begin
        #(25 * 20000);
        miscompares++;
        report_and_stop();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] v;
        logic [7:0]  hv;
        void'($urandom(32'h414D608A));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            rd(ba(IDX_HIGH[i]), 32'h0);
            rd(ba(IDX_SET[i]), 32'h0);
        end
        rd(ba(IDX_PERIOD), {20'h0, PERIOD_RST});
        rd(ba(IDX_CTRL), 32'h0);
        rd(ba(IDX_STATUS), 32'h0);
        for (int i = 0; i < 3; i++) begin
            v = $urandom;
            if (i == 0) hv = v[7:0];
            wr(ba(IDX_HIGH[i]), v);
            rd(ba(IDX_HIGH[i]), {24'h0, v[7:0]});
            v = $urandom & 32'hFFFF_FFFC;
            wr(ba(IDX_SET[i]), v);
            rd(ba(IDX_SET[i]), {24'h0, v[7:0]});
        end
        apb(1'b1, ba(IDX_C_RISE_HIGH), 32'h55, 4'hE, 33'h0);
        rd(ba(IDX_C_RISE_HIGH), {24'h0, hv});
        apb(1'b0, 12'hC00, 32'h0, 4'hF, {1'b1, 32'h0});
        apb(1'b1, 12'h125, 32'h0, 4'hF, {1'b1, 32'h0});
        apb(1'b0, 12'h524, 32'h0, 4'hF, {1'b1, 32'h0});
        apb(1'b1, 12'h524, 32'h0, 4'hF, {1'b1, 32'h0});
        rd(ba(IDX_C_RISE_HIGH), {24'h0, hv});
        wr(ba(IDX_PERIOD), 32'h28);
        wr(ba(IDX_C_RISE_HIGH), 32'h0);
        wr(ba(IDX_C_RISE_SET), 32'h0);
        wr(ba(IDX_C_FALL_HIGH), 32'h0);
        wr(ba(IDX_D_RISE_HIGH), 32'h0);
        wr(ba(IDX_D_RISE_SET), 32'h50);
        wr(ba(IDX_CTRL), 32'h1);
        rd(ba(IDX_CTRL), 32'h1);
        row(IDX_C_FALL_SET, 8'hA0, 12'h000, 8'd2, 8'd1);
        row(IDX_C_FALL_SET, 8'hA8, 12'h005, 8'd1, 8'd1);
        row(IDX_C_FALL_SET, 8'hAC, 12'h005, 8'd3, 8'd1);
        v = $urandom;
        row(IDX_C_FALL_SET, 8'hA4, v[11:0], 8'd2, 8'd1);
        row(IDX_C_FALL_HIGH, 8'h01, v[11:0], 8'd5, 8'd1);
        row(IDX_C_RISE_SET, 8'h50, v[11:0], 8'd4, 8'd0);
        repeat (4) @(posedge pclk);
        report_and_stop();
    end
endmodule

`default_nettype wire
